// ===== spf_pkg.sv
// Operation
// R1: interrupt on receive level at or above a 2-bit software threshold.
// R2: read-only 3-bit count of entries in the transmit FIFO.
// R3: read-only 3-bit count of entries in the receive FIFO.
// R4: word start on empty transmit FIFO sets status bit 5; status read clears.
// R5: status bits 4..1 track rx full, rx not empty, tx empty, tx not full.
// R6: status bit 0 high while a serial transfer is in progress.
// R7: five interrupt enables in bits 4..0, all set after reset.
// R8: masked status shows each cause only when its enable is set.
// R9: raw status shows the same five causes regardless of enables.
// R10: transmit-overflow clear read returns, clears cause; writes ignored.
// R11: receive-overflow clear read returns, clears cause; writes ignored.
// R12: receive-underflow clear read returns, clears cause; writes ignored.
// R13: reading the combined clear clears all three sticky causes at once.
// R14: DMA control bit 1 gates transmit requests, bit 0 receive requests.
// R15: 2-bit transmit DMA level, software writable.
// R16: 2-bit receive DMA level, software writable.
// R17: every data window word pushes transmit, pops receive, in order.
// R18: data port carries 16 bits in the low half of the word.
// R19: transmit DMA request while transmit count at or below its level.
// R20: receive DMA request while receive count at or above its level.
// R21: write to full tx FIFO or word into full rx FIFO flags overflow.
// R22: reading the data port with empty receive FIFO flags underflow.
// R23: transmit-empty cause at or below tx threshold; one OR-ed interrupt.
package spf_pkg;

    // register byte offsets
    localparam logic [7:0] OFS_TX_IRQ_THR = 8'h18;
    localparam logic [7:0] OFS_RX_IRQ_THR = 8'h1c;
    localparam logic [7:0] OFS_TX_LEVEL = 8'h20;
    localparam logic [7:0] OFS_RX_LEVEL = 8'h24;
    localparam logic [7:0] OFS_STATUS = 8'h28;
    localparam logic [7:0] OFS_IRQ_EN = 8'h2c;
    localparam logic [7:0] OFS_IRQ_MASKED = 8'h30;
    localparam logic [7:0] OFS_IRQ_RAW = 8'h34;
    localparam logic [7:0] OFS_TXO_CLR = 8'h38;
    localparam logic [7:0] OFS_RXO_CLR = 8'h3c;
    localparam logic [7:0] OFS_RXU_CLR = 8'h40;
    localparam logic [7:0] OFS_ALL_CLR = 8'h48;
    localparam logic [7:0] OFS_DMA_CTRL = 8'h4c;
    localparam logic [7:0] OFS_DMA_TX_LVL = 8'h50;
    localparam logic [7:0] OFS_DMA_RX_LVL = 8'h54;
    localparam logic [7:0] OFS_DATA_LO = 8'h60;
    localparam logic [7:0] OFS_DATA_HI = 8'hec;

    // status bit positions
    localparam int SR_BUSY = 0;
    localparam int SR_TX_NOT_FULL = 1;
    localparam int SR_TX_EMPTY = 2;
    localparam int SR_RX_NOT_EMPTY = 3;
    localparam int SR_RX_FULL = 4;
    localparam int SR_TX_START_EMPTY = 5;

    // interrupt cause bit positions
    localparam int IRQ_TX_EMPTY = 0;
    localparam int IRQ_TX_OVER = 1;
    localparam int IRQ_RX_UNDER = 2;
    localparam int IRQ_RX_OVER = 3;
    localparam int IRQ_RX_FULL = 4;

    // dma control bit positions
    localparam int DMA_RX_EN = 0;
    localparam int DMA_TX_EN = 1;

    // reset values
    localparam logic [4:0] IRQ_EN_RESET = 5'h1f;
    localparam logic [1:0] LEVEL_RESET = 2'h0;
    localparam logic [1:0] DMA_CTRL_RESET = 2'h0;

    // bits per serial word
    localparam int FRAME_BITS = 16;

    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } spf_bus_req_t;

    typedef enum {
        SPF_IDLE,
        SPF_SHIFT
    } spf_link_state_t;

endpackage

// ===== spf_regs.sv
`timescale 1ns/100ps
module spf_regs #(
    parameter int DEPTH = 4
) (
    // clock and reset
    input wire logic clock,
    input wire logic reset,
    // register port
    input wire spf_pkg::spf_bus_req_t bus,
    output logic [31:0] rdata,
    // requests out
    output logic irq,
    output logic tx_dma_req,
    output logic rx_dma_req,
    // serial link, slave side
    input wire logic sclk,
    input wire logic ss_n,
    input wire logic mosi,
    output logic miso,
    output logic miso_oe
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam logic [2:0] FULL_CNT = 3'(DEPTH);
    localparam logic [3:0] LAST_BIT = 4'(spf_pkg::FRAME_BITS - 1);

    ////////////////////////////////////////////////////////////////////////
    function automatic logic [PW-1:0] ptr_next(input logic [PW-1:0] p);
        ptr_next = (p == PW'(DEPTH - 1)) ? '0 : PW'(p + 1'b1);
    endfunction

    function automatic logic in_window(input logic [7:0] a);
        in_window = (a >= spf_pkg::OFS_DATA_LO) &&
            (a <= spf_pkg::OFS_DATA_HI) && (a[1:0] == 2'h0);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // software-visible state
    logic [1:0] tx_irq_level_q;
    logic [1:0] rx_irq_level_q;
    logic [4:0] irq_en_q;
    logic tx_dma_en_q;
    logic rx_dma_en_q;
    logic [1:0] tx_dma_level_q;
    logic [1:0] rx_dma_level_q;
    logic tx_over_q;
    logic rx_over_q;
    logic rx_under_q;
    logic tx_start_empty_q;
    logic [31:0] rdata_q;
    logic irq_q;
    logic tx_dma_req_q;
    logic rx_dma_req_q;

    // fifos
    logic [15:0] tx_mem_q [DEPTH];
    logic [15:0] rx_mem_q [DEPTH];
    logic [PW-1:0] tx_wp_q, tx_rp_q, rx_wp_q, rx_rp_q;
    logic [2:0] tx_cnt_q, rx_cnt_q;

    // link side
    logic sclk_s1_q, sclk_s2_q, sclk_s3_q;
    logic ss_s1_q, ss_s2_q;
    logic mosi_s1_q, mosi_s2_q;
    spf_pkg::spf_link_state_t state_q;
    logic [3:0] bit_cnt_q;
    logic [15:0] tx_shift_q;
    logic [15:0] rx_shift_q;
    logic miso_q;
    logic miso_oe_q;

    ////////////////////////////////////////////////////////////////////////
    // decode
    logic wr_win, rd_win, rd_status, rd_txo, rd_rxo, rd_rxu, rd_all;
    logic tx_full, tx_empty, rx_full, rx_empty;
    logic tx_push, tx_pop, rx_push, rx_pop;
    logic sclk_rise, sclk_fall, word_end, word_load;
    logic [15:0] rx_word;
    logic [4:0] raw, masked;

    assign wr_win = bus.wr && in_window(bus.addr);
    assign rd_win = bus.rd && in_window(bus.addr);
    assign rd_status = bus.rd && bus.addr == spf_pkg::OFS_STATUS;
    assign rd_txo = bus.rd && bus.addr == spf_pkg::OFS_TXO_CLR;
    assign rd_rxo = bus.rd && bus.addr == spf_pkg::OFS_RXO_CLR;
    assign rd_rxu = bus.rd && bus.addr == spf_pkg::OFS_RXU_CLR;
    assign rd_all = bus.rd && bus.addr == spf_pkg::OFS_ALL_CLR;

    assign tx_full = tx_cnt_q == FULL_CNT;
    assign tx_empty = tx_cnt_q == 3'h0;
    assign rx_full = rx_cnt_q == FULL_CNT;
    assign rx_empty = rx_cnt_q == 3'h0;

    assign sclk_rise = sclk_s2_q && !sclk_s3_q;
    assign sclk_fall = !sclk_s2_q && sclk_s3_q;
    assign word_end = state_q == spf_pkg::SPF_SHIFT && !ss_s2_q &&
        sclk_rise && bit_cnt_q == LAST_BIT;
    // next word loads on the fall after a word ends: a frame end pops nothing
    assign word_load = !ss_s2_q && (state_q == spf_pkg::SPF_IDLE ||
        (sclk_fall && bit_cnt_q == 4'h0));
    assign rx_word = {rx_shift_q[14:0], mosi_s2_q};

    assign tx_push = wr_win && !tx_full; // R17
    assign tx_pop = word_load && !tx_empty;
    assign rx_push = word_end && !rx_full;
    assign rx_pop = rd_win && !rx_empty; // R17

    assign raw[spf_pkg::IRQ_RX_FULL] = rx_cnt_q >= 3'(rx_irq_level_q); // R1
    assign raw[spf_pkg::IRQ_RX_OVER] = rx_over_q; // R9
    assign raw[spf_pkg::IRQ_RX_UNDER] = rx_under_q;
    assign raw[spf_pkg::IRQ_TX_OVER] = tx_over_q;
    assign raw[spf_pkg::IRQ_TX_EMPTY] = tx_cnt_q <= 3'(tx_irq_level_q); // R23
    assign masked = raw & irq_en_q; // R8

    ////////////////////////////////////////////////////////////////////////
    // control registers
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            tx_irq_level_q <= spf_pkg::LEVEL_RESET;
            rx_irq_level_q <= spf_pkg::LEVEL_RESET;
            irq_en_q <= spf_pkg::IRQ_EN_RESET; // R7
            tx_dma_en_q <= 1'b0;
            rx_dma_en_q <= 1'b0;
            tx_dma_level_q <= spf_pkg::LEVEL_RESET;
            rx_dma_level_q <= spf_pkg::LEVEL_RESET;
        end else if (bus.wr) begin
            case (bus.addr)
                spf_pkg::OFS_TX_IRQ_THR: tx_irq_level_q <= bus.wdata[1:0];
                spf_pkg::OFS_RX_IRQ_THR: rx_irq_level_q <= bus.wdata[1:0];
                spf_pkg::OFS_IRQ_EN: irq_en_q <= bus.wdata[4:0]; // R7
                spf_pkg::OFS_DMA_CTRL: begin
                    tx_dma_en_q <= bus.wdata[spf_pkg::DMA_TX_EN]; // R14
                    rx_dma_en_q <= bus.wdata[spf_pkg::DMA_RX_EN]; // R14
                end
                spf_pkg::OFS_DMA_TX_LVL: tx_dma_level_q <= bus.wdata[1:0];
                spf_pkg::OFS_DMA_RX_LVL: rx_dma_level_q <= bus.wdata[1:0];
                default: ;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // sticky causes; a set in the clearing cycle wins
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            tx_over_q <= 1'b0;
            rx_over_q <= 1'b0;
            rx_under_q <= 1'b0;
            tx_start_empty_q <= 1'b0;
        end else begin
            if (wr_win && tx_full)
                tx_over_q <= 1'b1; // R21
            else if (rd_txo || rd_all)
                tx_over_q <= 1'b0; // R10 R13
            if (word_end && rx_full)
                rx_over_q <= 1'b1; // R21
            else if (rd_rxo || rd_all)
                rx_over_q <= 1'b0; // R11 R13
            if (rd_win && rx_empty)
                rx_under_q <= 1'b1; // R22
            else if (rd_rxu || rd_all)
                rx_under_q <= 1'b0; // R12 R13
            if (word_load && tx_empty)
                tx_start_empty_q <= 1'b1; // R4
            else if (rd_status)
                tx_start_empty_q <= 1'b0; // R4
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read port: data valid only in the cycle after the strobe
    logic [31:0] rd_d;

    always_comb begin
        rd_d = 32'h0;
        case (bus.addr)
            spf_pkg::OFS_TX_IRQ_THR: rd_d[1:0] = tx_irq_level_q;
            spf_pkg::OFS_RX_IRQ_THR: rd_d[1:0] = rx_irq_level_q;
            spf_pkg::OFS_TX_LEVEL: rd_d[2:0] = tx_cnt_q; // R2
            spf_pkg::OFS_RX_LEVEL: rd_d[2:0] = rx_cnt_q; // R3
            spf_pkg::OFS_STATUS: begin
                rd_d[spf_pkg::SR_TX_START_EMPTY] = tx_start_empty_q; // R4
                rd_d[spf_pkg::SR_RX_FULL] = rx_full; // R5
                rd_d[spf_pkg::SR_RX_NOT_EMPTY] = !rx_empty; // R5
                rd_d[spf_pkg::SR_TX_EMPTY] = tx_empty; // R5
                rd_d[spf_pkg::SR_TX_NOT_FULL] = !tx_full; // R5
                rd_d[spf_pkg::SR_BUSY] = state_q == spf_pkg::SPF_SHIFT; // R6
            end
            spf_pkg::OFS_IRQ_EN: rd_d[4:0] = irq_en_q;
            spf_pkg::OFS_IRQ_MASKED: rd_d[4:0] = masked; // R8
            spf_pkg::OFS_IRQ_RAW: rd_d[4:0] = raw; // R9
            spf_pkg::OFS_TXO_CLR: rd_d[0] = tx_over_q; // R10
            spf_pkg::OFS_RXO_CLR: rd_d[0] = rx_over_q; // R11
            spf_pkg::OFS_RXU_CLR: rd_d[0] = rx_under_q; // R12
            spf_pkg::OFS_ALL_CLR: rd_d[0] = |raw[3:1]; // R13
            spf_pkg::OFS_DMA_CTRL: begin
                rd_d[spf_pkg::DMA_TX_EN] = tx_dma_en_q;
                rd_d[spf_pkg::DMA_RX_EN] = rx_dma_en_q;
            end
            spf_pkg::OFS_DMA_TX_LVL: rd_d[1:0] = tx_dma_level_q;
            spf_pkg::OFS_DMA_RX_LVL: rd_d[1:0] = rx_dma_level_q;
            default: begin
                if (in_window(bus.addr) && !rx_empty)
                    rd_d[15:0] = rx_mem_q[rx_rp_q]; // R18
            end
        endcase
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset)
            rdata_q <= 32'h0;
        else
            rdata_q <= bus.rd ? rd_d : 32'h0;
    end

    ////////////////////////////////////////////////////////////////////////
    // transmit fifo
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            tx_wp_q <= '0;
            for (int i = 0; i < DEPTH; i++)
                tx_mem_q[i] <= 16'h0;
        end else if (tx_push) begin
            tx_mem_q[tx_wp_q] <= bus.wdata[15:0]; // R18
            tx_wp_q <= ptr_next(tx_wp_q);
        end
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            tx_rp_q <= '0;
            tx_cnt_q <= 3'h0;
        end else begin
            if (tx_pop)
                tx_rp_q <= ptr_next(tx_rp_q);
            if (tx_push && !tx_pop)
                tx_cnt_q <= tx_cnt_q + 3'h1; // R2
            else if (tx_pop && !tx_push)
                tx_cnt_q <= tx_cnt_q - 3'h1;
        end
    end

    // receive fifo
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            rx_wp_q <= '0;
            for (int i = 0; i < DEPTH; i++)
                rx_mem_q[i] <= 16'h0;
        end else if (rx_push) begin
            rx_mem_q[rx_wp_q] <= rx_word;
            rx_wp_q <= ptr_next(rx_wp_q);
        end
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            rx_rp_q <= '0;
            rx_cnt_q <= 3'h0;
        end else begin
            if (rx_pop)
                rx_rp_q <= ptr_next(rx_rp_q);
            if (rx_push && !rx_pop)
                rx_cnt_q <= rx_cnt_q + 3'h1; // R3
            else if (rx_pop && !rx_push)
                rx_cnt_q <= rx_cnt_q - 3'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // request outputs
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            irq_q <= 1'b0;
            tx_dma_req_q <= 1'b0;
            rx_dma_req_q <= 1'b0;
        end else begin
            irq_q <= |masked; // R23
            tx_dma_req_q <= tx_dma_en_q &&
                tx_cnt_q <= 3'(tx_dma_level_q); // R15 R19
            rx_dma_req_q <= rx_dma_en_q &&
                rx_cnt_q >= 3'(rx_dma_level_q); // R16 R20
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // pin synchronisers; third sclk stage only feeds edge detection
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            sclk_s1_q <= 1'b0;
            sclk_s2_q <= 1'b0;
            sclk_s3_q <= 1'b0;
            ss_s1_q <= 1'b1;
            ss_s2_q <= 1'b1;
            mosi_s1_q <= 1'b0;
            mosi_s2_q <= 1'b0;
        end else begin
            sclk_s1_q <= sclk;
            sclk_s2_q <= sclk_s1_q;
            sclk_s3_q <= sclk_s2_q;
            ss_s1_q <= ss_n;
            ss_s2_q <= ss_s1_q;
            mosi_s1_q <= mosi;
            mosi_s2_q <= mosi_s1_q;
        end
    end

    // slave shifter, clock idle low, sample on rise, change on fall
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            state_q <= spf_pkg::SPF_IDLE;
            bit_cnt_q <= 4'h0;
            tx_shift_q <= 16'h0;
            rx_shift_q <= 16'h0;
        end else begin
            case (state_q)
                spf_pkg::SPF_IDLE: begin
                    if (!ss_s2_q)
                        state_q <= spf_pkg::SPF_SHIFT; // R6
                end
                spf_pkg::SPF_SHIFT: begin
                    if (ss_s2_q) begin
                        state_q <= spf_pkg::SPF_IDLE; // R6
                    end else if (sclk_rise) begin
                        rx_shift_q <= rx_word;
                        bit_cnt_q <= (bit_cnt_q == LAST_BIT) ? 4'h0 :
                            bit_cnt_q + 4'h1;
                    end else if (sclk_fall && bit_cnt_q != 4'h0) begin
                        tx_shift_q <= {tx_shift_q[14:0], 1'b0};
                    end
                end
                default: state_q <= spf_pkg::SPF_IDLE;
            endcase
            // an empty fifo at word start sends zeros
            if (word_load) begin
                tx_shift_q <= tx_empty ? 16'h0 : tx_mem_q[tx_rp_q];
                if (state_q == spf_pkg::SPF_IDLE)
                    bit_cnt_q <= 4'h0;
            end
        end
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            miso_q <= 1'b0;
            miso_oe_q <= 1'b0;
        end else begin
            miso_q <= tx_shift_q[15];
            miso_oe_q <= state_q == spf_pkg::SPF_SHIFT && !ss_s2_q;
        end
    end

    assign rdata = rdata_q;
    assign irq = irq_q;
    assign tx_dma_req = tx_dma_req_q;
    assign rx_dma_req = rx_dma_req_q;
    assign miso = miso_q;
    assign miso_oe = miso_oe_q;

    ////////////////////////////////////////////////////////////////////////
    a_tx_level_read: assert property ( // R2
        @(posedge clock) disable iff (reset)
        bus.rd && bus.addr == spf_pkg::OFS_TX_LEVEL
        |=> rdata_q == {29'h0, $past(tx_cnt_q)})
        else $error("transmit level readback wrong");

    a_rx_push_count: assert property ( // R3
        @(posedge clock) disable iff (reset)
        rx_push && !rx_pop |=> rx_cnt_q == $past(rx_cnt_q) + 3'h1)
        else $error("receive count did not grow");

    a_start_empty_set: assert property ( // R4
        @(posedge clock) disable iff (reset)
        word_load && tx_empty |=> tx_start_empty_q ##1 tx_start_empty_q
            || $past(rd_status))
        else $error("start-empty flag not held");

    a_status_clears: assert property ( // R4
        @(posedge clock) disable iff (reset)
        rd_status && !(word_load && tx_empty) |=> !tx_start_empty_q)
        else $error("status read did not clear flag");

    a_busy_frame: assert property ( // R6
        @(posedge clock) disable iff (reset)
        $fell(ss_s2_q) |=> rd_d[spf_pkg::SR_BUSY] ||
            bus.addr != spf_pkg::OFS_STATUS ##0 state_q == spf_pkg::SPF_SHIFT)
        else $error("busy not raised at frame start");

    a_tx_over_set: assert property ( // R21
        @(posedge clock) disable iff (reset)
        wr_win && tx_full |=> tx_over_q && tx_cnt_q <= FULL_CNT)
        else $error("transmit overflow not flagged");

    a_txo_clear: assert property ( // R10
        @(posedge clock) disable iff (reset)
        rd_txo && !(wr_win && tx_full) |=> !tx_over_q
            && rdata_q[0] == $past(tx_over_q))
        else $error("transmit overflow clear read wrong");

    a_under_set: assert property ( // R22
        @(posedge clock) disable iff (reset)
        rd_win && rx_empty |=> rx_under_q && rdata_q == 32'h0)
        else $error("receive underflow not flagged");

    a_irq_masked: assert property ( // R23
        @(posedge clock) disable iff (reset)
        (raw & irq_en_q) == 5'h0 ##1 (raw & irq_en_q) == 5'h0 |-> !irq_q)
        else $error("interrupt with every cause masked");

    a_tx_dma_gate: assert property ( // R19
        @(posedge clock) disable iff (reset)
        !tx_dma_en_q |=> !tx_dma_req_q)
        else $error("transmit dma request while disabled");

    a_rx_dma_level: assert property ( // R20
        @(posedge clock) disable iff (reset)
        rx_dma_en_q && rx_cnt_q >= {1'b0, rx_dma_level_q} |=> rx_dma_req_q)
        else $error("receive dma request missing");

endmodule

// ===== spf_link_master.sv
`timescale 1ns/100ps
module spf_link_master (
    // serial link, master side
    output logic sclk,
    output logic ss_n,
    output logic mosi,
    input wire logic miso
);
    initial begin
        sclk = 1'b0;
        ss_n = 1'b1;
        mosi = 1'b1;
    end

    // one mode 0 frame of 16 bits, msb first; clock idles low between frames
    task automatic xfer(input logic [15:0] tx, output logic [15:0] rx);
        // small offset keeps link edges away from the system clock edges
        #3 ss_n = 1'b0;
        #80;
        for (int i = 15; i >= 0; i--) begin
            mosi = tx[i];
            #40 sclk = 1'b1;
            rx[i] = miso;
            #40 sclk = 1'b0;
        end
        ss_n = 1'b1;
        // released data line shows the inverse, not a stale copy
        mosi = ~tx[0];
        #200;
    endtask
endmodule

// ===== spf_regs_tb.sv
`timescale 1ns/100ps
module spf_regs_tb;
    logic clock = 1'b0;
    logic reset = 1'b1;
    spf_pkg::spf_bus_req_t bus = '0;
    logic [31:0] rdata;
    logic irq, tx_dma_req, rx_dma_req;
    logic sclk, ss_n, mosi, miso, miso_oe;
    wire logic miso_w;
    logic [15:0] got;
    int miscompares = 0;
    int compares = 0;
    logic [7:0] ra [15] = '{8'h1c, 8'h20, 8'h24, 8'h28, 8'h2c, 8'h30,
        8'h34, 8'h38, 8'h3c, 8'h40, 8'h48, 8'h4c, 8'h50, 8'h54, 8'h5c};
    logic [31:0] rv [15] = '{32'h0, 32'h0, 32'h0, 32'h6, 32'h1f, 32'h11,
        32'h11, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0};
    logic [7:0] lv [4] = '{8'h1c, 8'h50, 8'h54, 8'h4c};
    logic [15:0] m [5] = '{16'h8001, 16'h5a3c, 16'hc3a5, 16'h7ffe, 16'h1234};

    always #5 clock = ~clock;
    // a sample taken while the slave is released reads as high impedance (z)
    assign miso_w = miso_oe ? miso : 1'bz;

    spf_regs #(.DEPTH(4)) spf_regs_inst (.clock(clock), .reset(reset),
        .bus(bus), .rdata(rdata), .irq(irq), .tx_dma_req(tx_dma_req),
        .rx_dma_req(rx_dma_req), .sclk(sclk), .ss_n(ss_n), .mosi(mosi),
        .miso(miso), .miso_oe(miso_oe));
    spf_link_master spf_link_master_inst (.sclk(sclk), .ss_n(ss_n),
        .mosi(mosi), .miso(miso_w));

    ////////////////////////////////////////
    task automatic check(input string what, input logic [31:0] exp,
        input logic [31:0] seen);
        compares++;
        if (seen !== exp) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus.addr <= a;
        bus.wdata <= d;
        bus.wr <= 1'b1;
        @(posedge clock);
        bus.wr <= 1'b0;
        @(posedge clock);
    endtask

    // read data stand only in the cycle after the strobe
    task automatic rchk(input logic [7:0] a, input logic [31:0] exp,
        input string what);
        bus.addr <= a;
        bus.rd <= 1'b1;
        @(posedge clock);
        bus.rd <= 1'b0;
        @(negedge clock);
        check(what, exp, rdata);
        @(posedge clock);
    endtask

    task automatic pin(input string what, input logic exp, ref logic sig);
        @(negedge clock);
        check(what, {31'h0, exp}, {31'h0, sig});
        @(posedge clock);
    endtask

    task automatic report_and_stop();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    ////////////////////////////////////////
    initial begin
        repeat (8) @(posedge clock);
        reset <= 1'b0;
        @(posedge clock);
        for (int i = 0; i < 15; i++) begin
            rchk(ra[i], rv[i], "reset value");
        end
        pin("irq", 1'b1, irq);
        wr(8'h2c, 32'h0);
        rchk(8'h30, 32'h0, "masked");
        rchk(8'h34, 32'h11, "raw");
        pin("irq", 1'b0, irq);
        wr(8'h2c, 32'hffff_ffff);
        rchk(8'h2c, 32'h1f, "irq enable");
        foreach (lv[i]) begin
            wr(lv[i], 32'hffff_ffff);
            rchk(lv[i], 32'h3, "level field");
        end
        pin("tx dma", 1'b1, tx_dma_req);
        pin("rx dma", 1'b0, rx_dma_req);
        wr(8'h4c, 32'h1);
        pin("tx dma gated", 1'b0, tx_dma_req);
        wr(8'h4c, 32'h3);
        wr(8'h20, 32'h7);
        for (int i = 0; i < 4; i++) begin
            wr(8'h60 + 8'(i * 44), {16'hffff, 16'h9100 + 16'(i)});
        end
        pin("tx dma", 1'b0, tx_dma_req);
        rchk(8'h20, 32'h4, "tx level");
        rchk(8'h28, 32'h0, "status");
        wr(8'hec, 32'h0);
        rchk(8'h20, 32'h4, "tx level");
        wr(8'h38, 32'h0);
        rchk(8'h34, 32'h2, "raw");
        rchk(8'h38, 32'h1, "tx over clear");
        rchk(8'h38, 32'h0, "tx over clear");
        rchk(8'h60, 32'h0, "empty read");
        rchk(8'h34, 32'h4, "raw");
        rchk(8'h40, 32'h1, "rx under clear");
        rchk(8'h40, 32'h0, "rx under clear");
        wr(8'hec, 32'h0);
        rchk(8'h64, 32'h0, "empty read");
        rchk(8'h34, 32'h6, "raw");
        rchk(8'h48, 32'h1, "combined clear");
        rchk(8'h34, 32'h0, "raw");
        wr(8'h1c, 32'h2);
        wr(8'h54, 32'h2);
        wr(8'h2c, 32'h10);
        // five frames: tx runs dry and the fifth word overflows rx
        for (int i = 0; i < 5; i++) begin
            fork
                spf_link_master_inst.xfer(m[i], got);
                if (i == 0) begin
                    #400;
                    @(posedge clock);
                    rchk(8'h28, 32'h3, "status busy");
                end
            join
            @(posedge clock);
            if (i == 0) begin
                check("miso word", 32'h9100, {16'h0, got});
                rchk(8'h24, 32'h1, "rx level");
                rchk(8'h30, 32'h0, "rx full masked");
                pin("rx dma", 1'b0, rx_dma_req);
                pin("tx dma", 1'b1, tx_dma_req);
            end
            if (i == 1) begin
                check("miso word", 32'h9101, {16'h0, got});
                rchk(8'h30, 32'h10, "rx full masked");
                pin("rx dma", 1'b1, rx_dma_req);
            end
        end
        rchk(8'h24, 32'h4, "rx level");
        rchk(8'h28, 32'h3e, "status");
        rchk(8'h28, 32'h1e, "status");
        rchk(8'h34, 32'h19, "raw");
        rchk(8'h3c, 32'h1, "rx over clear");
        rchk(8'h3c, 32'h0, "rx over clear");
        for (int i = 0; i < 4; i++) begin
            rchk(8'h60 + 8'(i * 4), {16'h0, m[i]}, "rx word");
        end
        rchk(8'h24, 32'h0, "rx level");
        report_and_stop();
    end

    // whole run is some 9.4 us; this limit only cuts a hang short
    initial begin
        #200000;
        miscompares++;
        report_and_stop();
    end
endmodule
